// File: dtc_common_ctrl.sv
// Functional notes
// R1 - Mode bit 0 selects transmit, 1 selects demodulation for both timers.
// R2 - Transmit: bit 6 puts port value or combined timer output on pin six.
// R3 - Demodulation: bit 6 picks input, port three pin one or port two pin zero.
// R4 - Pin-one captures also raise second port interrupt unless its own or the global mask bit is clear.
// R5 - Bits 5-4: transmit combining gate; demodulation edge select, 11 reserved.
// R6 - Bit 1: short output initial level, or rising-edge flag cleared by writing 1.
// R7 - Bit 0: long output initial level, or falling-edge flag cleared by writing 1.
// R8 - Ping-pong: hardware alternately sets and clears both timer enable bits.
// R9 - Ping-pong: each timer sets its timeout bit at every terminal count.
// R10 - Capture mask set: interrupt request on every demodulation capture.
// R11 - Counter mask set: interrupt request on every short timer timeout.
// R12 - Dedicated bit selects port output or short timer output on pin four.
// R13 - Pin outputs steered by bit 6 and each timer control bit 0.
// R14 - Fields clear at reset; bits 5-4 survive stop-mode recovery.
// R15 - Timer registers live in expanded register bank D, selected by pointer.
// R16 - Two timer interrupt sources, each gated by own and global mask.
// R17 - Bits 3-2: transmit submode or forced long output; demodulation glitch filter.
`include "dtc_map.svh"

module dtc_common_ctrl #(
    parameter int FILT_W = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_stop_recovery,
    input wire logic [3:0] i_reg_bank,
    input wire logic [3:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire dtc_pkg::dtc_byte_t i_reg_wdata,
    output dtc_pkg::dtc_byte_t o_reg_rdata,
    input wire logic i_short_tc,
    input wire logic i_long_tc,
    output logic o_short_run,
    output logic o_long_run,
    input wire logic i_port_three_pin_one,
    input wire logic i_port_two_pin_zero,
    input wire logic i_pin_four_port_data,
    input wire logic i_pin_five_port_data,
    input wire logic i_pin_six_port_data,
    output logic o_port_three_pin_four,
    output logic o_port_three_pin_five,
    output logic o_port_three_pin_six,
    input wire dtc_pkg::dtc_byte_t i_interrupt_mask,
    output logic o_capture,
    output logic o_capture_irq,
    output logic o_counter_irq,
    output logic o_second_port_irq
);
    import dtc_pkg::*;

    // Common control fields
    logic mode_q;
    logic sel_q;
    logic [1:0] logic_q;
    logic [1:0] sub_q;
    logic init_short_q;
    logic init_long_q;
    logic rise_flag_q;
    logic fall_flag_q;
    dtc_byte_t short_ctl_q;
    dtc_byte_t long_ctl_q;
    dtc_byte_t extra_q;
    dtc_byte_t rdata_q;
    logic short_out_q;
    logic long_out_q;
    logic short_run_prev_q;
    logic long_run_prev_q;
    logic pin4_q;
    logic pin5_q;
    logic pin6_q;
    logic capture_q;
    logic cap_irq_q;
    logic cnt_irq_q;
    logic port2_irq_q;

    wire logic bank_hit = i_reg_bank == `DTC_BANK; // R15
    wire logic wr_short = bank_hit & i_reg_wr & (i_reg_addr == `DTC_OFS_SHORT_CTL);
    wire logic wr_common = bank_hit & i_reg_wr & (i_reg_addr == `DTC_OFS_COMMON);
    wire logic wr_long = bank_hit & i_reg_wr & (i_reg_addr == `DTC_OFS_LONG_CTL);
    wire logic wr_extra = bank_hit & i_reg_wr & (i_reg_addr == `DTC_OFS_EXTRA);
    wire logic demod = mode_q; // R1
    wire logic xmit = ~mode_q; // R1

    // Demodulation input path
    wire logic demod_pin = sel_q ? i_port_two_pin_zero : i_port_three_pin_one; // R3
    logic [FILT_W-1:0] filt_len;
    logic pin_rise;
    logic pin_fall;

    always_comb begin
        case (dtc_sub_t'(sub_q))
            DTC_SUB_NORMAL: filt_len = FILT_W'(`DTC_FILT_NONE); // R17
            DTC_SUB_PINGPONG: filt_len = FILT_W'(`DTC_FILT_4); // R17
            DTC_SUB_LONG_LOW: filt_len = FILT_W'(`DTC_FILT_8); // R17
            default: filt_len = FILT_W'(`DTC_FILT_NONE);
        endcase
    end

    dtc_input_filter #(
        .CNT_W(FILT_W)
    ) u_filter (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_pin(demod_pin),
        .i_len(filt_len),
        .o_rise(pin_rise),
        .o_fall(pin_fall)
    );

    wire logic rise_ev = demod & pin_rise;
    wire logic fall_ev = demod & pin_fall;
    logic capture_ev;

    always_comb begin
        case (dtc_edge_t'(logic_q))
            DTC_EDGE_FALL: capture_ev = fall_ev; // R5
            DTC_EDGE_RISE: capture_ev = rise_ev; // R5
            DTC_EDGE_BOTH: capture_ev = rise_ev | fall_ev; // R5
            default: capture_ev = 1'b0;
        endcase
    end

    // Ping-pong hand-over between the two timers
    wire logic pingpong = xmit & (sub_q == DTC_SUB_PINGPONG);
    wire logic pp_short_done = pingpong & i_short_tc & short_ctl_q[`DTC_B_ENABLE];
    wire logic pp_long_done = pingpong & i_long_tc & long_ctl_q[`DTC_B_ENABLE];

    dtc_byte_t short_ctl_d;
    dtc_byte_t long_ctl_d;

    always_comb begin
        short_ctl_d = short_ctl_q;
        long_ctl_d = long_ctl_q;
        if (wr_short) begin
            short_ctl_d = i_reg_wdata;
            short_ctl_d[`DTC_B_TIMEOUT] = short_ctl_q[`DTC_B_TIMEOUT]
                & ~i_reg_wdata[`DTC_B_TIMEOUT];
        end
        if (wr_long) begin
            long_ctl_d = i_reg_wdata;
            long_ctl_d[`DTC_B_TIMEOUT] = long_ctl_q[`DTC_B_TIMEOUT]
                & ~i_reg_wdata[`DTC_B_TIMEOUT];
        end
        if (pp_short_done) begin
            short_ctl_d[`DTC_B_ENABLE] = 1'b0; // R8
            long_ctl_d[`DTC_B_ENABLE] = 1'b1; // R8
        end
        if (pp_long_done) begin
            long_ctl_d[`DTC_B_ENABLE] = 1'b0; // R8
            short_ctl_d[`DTC_B_ENABLE] = 1'b1; // R8
        end
        // Timeout set wins over a clearing write
        if (i_short_tc) begin
            short_ctl_d[`DTC_B_TIMEOUT] = 1'b1; // R9
        end
        if (i_long_tc) begin
            long_ctl_d[`DTC_B_TIMEOUT] = 1'b1; // R9
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            short_ctl_q <= `DTC_RST_BYTE;
            long_ctl_q <= `DTC_RST_BYTE;
            extra_q <= `DTC_RST_BYTE;
        end else begin
            short_ctl_q <= short_ctl_d;
            long_ctl_q <= long_ctl_d;
            if (wr_extra) begin
                extra_q <= i_reg_wdata;
            end
        end
    end

    // Common control register; edge flags set wins over clear
    wire logic rise_flag_d = rise_ev
        | (rise_flag_q & ~(wr_common & demod & i_reg_wdata[`DTC_B_INIT_SHORT])); // R6
    wire logic fall_flag_d = fall_ev
        | (fall_flag_q & ~(wr_common & demod & i_reg_wdata[`DTC_B_INIT_LONG])); // R7

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            mode_q <= 1'b0; // R14
            sel_q <= 1'b0;
            logic_q <= 2'b00;
            sub_q <= 2'b00;
            init_short_q <= 1'b0;
            init_long_q <= 1'b0;
            rise_flag_q <= 1'b0;
            fall_flag_q <= 1'b0;
        end else if (i_stop_recovery) begin
            mode_q <= 1'b0; // R14
            sel_q <= 1'b0;
            sub_q <= 2'b00;
            init_short_q <= 1'b0;
            init_long_q <= 1'b0;
            rise_flag_q <= 1'b0;
            fall_flag_q <= 1'b0;
        end else begin
            rise_flag_q <= rise_flag_d;
            fall_flag_q <= fall_flag_d;
            if (wr_common) begin
                mode_q <= i_reg_wdata[`DTC_B_MODE];
                sel_q <= i_reg_wdata[`DTC_B_SEL];
                logic_q <= i_reg_wdata[`DTC_B_LOGIC_HI:`DTC_B_LOGIC_LO];
                sub_q <= i_reg_wdata[`DTC_B_SUB_HI:`DTC_B_SUB_LO];
            end
            if (wr_common && xmit) begin
                init_short_q <= i_reg_wdata[`DTC_B_INIT_SHORT]; // R6
                init_long_q <= i_reg_wdata[`DTC_B_INIT_LONG]; // R7
            end
        end
    end

    // Read view depends on mode for the two low bits
    wire logic bit1_view = demod ? rise_flag_q : init_short_q; // R6
    wire logic bit0_view = demod ? fall_flag_q : init_long_q; // R7
    wire dtc_byte_t common_view = {mode_q, sel_q, logic_q, sub_q, bit1_view, bit0_view};
    dtc_byte_t rd_mux;

    always_comb begin
        case (i_reg_addr)
            `DTC_OFS_SHORT_CTL: rd_mux = short_ctl_q;
            `DTC_OFS_COMMON: rd_mux = common_view;
            `DTC_OFS_LONG_CTL: rd_mux = long_ctl_q;
            `DTC_OFS_EXTRA: rd_mux = extra_q;
            default: rd_mux = `DTC_RST_BYTE;
        endcase
    end

    wire logic rd_hit = bank_hit & i_reg_rd; // R15

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rdata_q <= `DTC_RST_BYTE;
        end else if (rd_hit) begin
            rdata_q <= rd_mux;
        end
    end

    // Transmit waveforms: load initial level at start, toggle at terminal count
    wire logic short_run = short_ctl_q[`DTC_B_ENABLE];
    wire logic long_run = long_ctl_q[`DTC_B_ENABLE];
    wire logic short_start = short_run & ~short_run_prev_q;
    wire logic long_start = long_run & ~long_run_prev_q;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            short_out_q <= 1'b0;
            long_out_q <= 1'b0;
            short_run_prev_q <= 1'b0;
            long_run_prev_q <= 1'b0;
        end else begin
            short_run_prev_q <= short_run;
            long_run_prev_q <= long_run;
            if (short_start) begin
                short_out_q <= init_short_q; // R6
            end else if (i_short_tc && xmit) begin
                short_out_q <= ~short_out_q;
            end
            if (long_start) begin
                long_out_q <= init_long_q; // R7
            end else if (i_long_tc && xmit) begin
                long_out_q <= ~long_out_q;
            end
        end
    end

    // Forced long output levels
    logic long_eff;
    always_comb begin
        case (dtc_sub_t'(sub_q))
            DTC_SUB_LONG_LOW: long_eff = 1'b0; // R17
            DTC_SUB_LONG_HIGH: long_eff = 1'b1; // R17
            default: long_eff = long_out_q;
        endcase
    end

    logic combined;
    always_comb begin
        case (dtc_gate_t'(logic_q))
            DTC_GATE_AND: combined = short_out_q & long_eff; // R5
            DTC_GATE_OR: combined = short_out_q | long_eff; // R5
            DTC_GATE_NOR: combined = ~(short_out_q | long_eff); // R5
            DTC_GATE_NAND: combined = ~(short_out_q & long_eff); // R5
            default: combined = 1'b0;
        endcase
    end

    wire logic pin4_d = (extra_q[`DTC_B_PIN4_SEL] & short_ctl_q[`DTC_B_OUT_EN])
        ? short_out_q : i_pin_four_port_data; // R12
    wire logic pin5_d = long_ctl_q[`DTC_B_OUT_EN] ? long_eff : i_pin_five_port_data; // R13
    wire logic pin6_d = (xmit & sel_q) ? combined : i_pin_six_port_data; // R2

    // Interrupt requests
    wire logic global_en = i_interrupt_mask[`DTC_IMR_GLOBAL];
    wire logic cap_irq_d = capture_ev & extra_q[`DTC_B_CAP_MASK] & global_en; // R10
    wire logic cnt_irq_d = i_short_tc & extra_q[`DTC_B_CNT_MASK] & global_en; // R11
    wire logic port2_irq_d = capture_ev & ~sel_q
        & i_interrupt_mask[`DTC_IMR_PORT2] & global_en; // R4

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pin4_q <= 1'b0;
            pin5_q <= 1'b0;
            pin6_q <= 1'b0;
            capture_q <= 1'b0;
            cap_irq_q <= 1'b0;
            cnt_irq_q <= 1'b0;
            port2_irq_q <= 1'b0;
        end else begin
            pin4_q <= pin4_d;
            pin5_q <= pin5_d; // R13
            pin6_q <= pin6_d;
            capture_q <= capture_ev;
            cap_irq_q <= cap_irq_d; // R16
            cnt_irq_q <= cnt_irq_d; // R16
            port2_irq_q <= port2_irq_d;
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_short_run = short_run;
    assign o_long_run = long_run;
    assign o_port_three_pin_four = pin4_q;
    assign o_port_three_pin_five = pin5_q;
    assign o_port_three_pin_six = pin6_q;
    assign o_capture = capture_q;
    assign o_capture_irq = cap_irq_q;
    assign o_counter_irq = cnt_irq_q;
    assign o_second_port_irq = port2_irq_q;
endmodule : dtc_common_ctrl

// File: dtc_common_ctrl_checker.sv
`include "dtc_map.svh"

module dtc_common_ctrl_checker (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_stop_recovery,
    input wire logic [3:0] i_reg_bank,
    input wire logic [3:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire dtc_pkg::dtc_byte_t i_reg_wdata,
    input wire dtc_pkg::dtc_byte_t o_reg_rdata,
    input wire logic i_short_tc,
    input wire logic o_short_run,
    input wire logic o_long_run,
    input wire logic i_port_three_pin_one,
    input wire logic i_pin_six_port_data,
    input wire logic o_port_three_pin_six,
    input wire dtc_pkg::dtc_byte_t i_interrupt_mask,
    input wire logic o_capture,
    input wire logic o_capture_irq,
    input wire logic o_counter_irq,
    input wire logic o_second_port_irq
);
    import dtc_pkg::*;
    dtc_byte_t cm_q;
    dtc_byte_t ex_q;
    wire hit = i_reg_wr && i_reg_bank == `DTC_BANK;
    wire [7:0] m = i_interrupt_mask;

    // Mirror of the common and extra registers
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cm_q <= 8'h00;
            ex_q <= 8'h00;
        end else begin
            if (i_stop_recovery) cm_q <= cm_q & 8'h30;
            else if (hit && i_reg_addr == 4'h1) cm_q <= i_reg_wdata;
            if (hit && i_reg_addr == 4'h3) ex_q <= i_reg_wdata;
        end
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    property p_reset_quiet;
        $fell(i_rst) |-> !o_capture && !o_counter_irq && o_reg_rdata == 8'h00 && !o_short_run;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("output active after reset");
    property p_pin_six_port;
        cm_q[7] || !cm_q[6] |=> o_port_three_pin_six == $past(i_pin_six_port_data);
    endproperty
    a_pin_six_port: assert property (p_pin_six_port) else $error("pin six not port data");
    property p_no_cap_xmit;
        !cm_q[7] [*8] |-> !o_capture;
    endproperty
    a_no_cap_xmit: assert property (p_no_cap_xmit) else $error("capture in transmit");
    property p_reserved;
        (cm_q[7] && cm_q[5:4] == 2'b11) [*8] |-> !o_capture;
    endproperty
    a_reserved: assert property (p_reserved) else $error("capture on reserved edge");
    property p_latency;
        cm_q[7:2] == 6'b100100 && $rose(i_port_three_pin_one) |-> ##[3:5] o_capture;
    endproperty
    a_latency: assert property (p_latency) else $error("rising edge not captured");
    property p_cap_irq;
        o_capture |-> o_capture_irq == (ex_q[2] && m[7]);
    endproperty
    a_cap_irq: assert property (p_cap_irq) else $error("capture request wrong");
    property p_port_irq;
        o_capture |-> o_second_port_irq == (!cm_q[6] && m[2] && m[7]);
    endproperty
    a_port_irq: assert property (p_port_irq) else $error("port request wrong");
    property p_cnt_irq;
        i_short_tc && ex_q[1] && m[7] |-> ##[1:2] o_counter_irq;
    endproperty
    a_cnt_irq: assert property (p_cnt_irq) else $error("counter request missing");
    property p_pingpong;
        !cm_q[7] && cm_q[3:2] == 2'b01 && o_short_run && !o_long_run && i_short_tc
            |=> !o_short_run && o_long_run;
    endproperty
    a_pingpong: assert property (p_pingpong) else $error("enables did not swap");
    c_capture: cover property (o_capture_irq);
    c_swap: cover property (o_short_run ##1 o_long_run);
    c_count: cover property (o_counter_irq);
endmodule : dtc_common_ctrl_checker

bind dtc_common_ctrl dtc_common_ctrl_checker u_chk (
    .i_clk_sys, .i_rst, .i_stop_recovery, .i_reg_bank, .i_reg_addr, .i_reg_wr, .i_reg_wdata,
    .o_reg_rdata, .i_short_tc, .o_short_run, .o_long_run, .i_port_three_pin_one,
    .i_pin_six_port_data, .o_port_three_pin_six, .i_interrupt_mask, .o_capture,
    .o_capture_irq, .o_counter_irq, .o_second_port_irq
);

// File: dtc_common_ctrl_test.sv
`include "dtc_map.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %0t %h %h", $time, g, e); end end

module dtc_common_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    import dtc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, stop = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
    logic p31 = 1'b0, p20 = 1'b0, d4 = 1'b0, d5 = 1'b0, d6 = 1'b0;
    logic [3:0] bank = 4'h0, addr = 4'h0;
    dtc_byte_t wdata = 8'h00, interrupt_mask = 8'h00, rdata, exp_b;
    dtc_byte_t expq[$];
    logic stc, ltc, srun, lrun, pin4, pin5, pin6, cap, capi, cnti, p2i;
    logic [31:0] seed = 32'hbe88_4255;
    int n[5];
    int ec, cyc, mismatches, total_checks;

    dtc_common_ctrl uut (.i_clk_sys(clk), .i_rst(rst), .i_stop_recovery(stop),
        .i_reg_bank(bank), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_short_tc(stc), .i_long_tc(ltc),
        .o_short_run(srun), .o_long_run(lrun), .i_port_three_pin_one(p31),
        .i_port_two_pin_zero(p20), .i_pin_four_port_data(d4), .i_pin_five_port_data(d5),
        .i_pin_six_port_data(d6), .o_port_three_pin_four(pin4),
        .o_port_three_pin_five(pin5), .o_port_three_pin_six(pin6),
        .i_interrupt_mask(interrupt_mask), .o_capture(cap), .o_capture_irq(capi),
        .o_counter_irq(cnti), .o_second_port_irq(p2i));
    dtc_timer_model u_tmr (.i_clk_sys(clk), .i_rst(rst), .i_go(go), .i_short_run(srun),
        .i_long_run(lrun), .o_short_tc(stc), .o_long_tc(ltc));

    always #20 clk = ~clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic gate(input logic [3:0] k);
        return k[3] ^ ((k[3] ^ k[2]) ? (k[1] | k[0]) : (k[1] & k[0]));
    endfunction : gate
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : tick
    task automatic acc(input logic [3:0] b, a, input logic rw, input dtc_byte_t d);
        @(posedge clk);
        #1;
        bank = b;
        addr = a;
        wdata = d;
        rd = rw;
        wr = !rw;
        if (rw) expq.push_back(d);
        tick(1);
        rd = 1'b0;
        wr = 1'b0;
    endtask : acc
    task automatic put(input logic [3:0] a, input dtc_byte_t d);
        acc(4'hD, a, 1'b0, d);
    endtask : put
    task automatic get(input logic [3:0] a, input dtc_byte_t e);
        acc(4'hD, a, 1'b1, e);
    endtask : get
    task automatic pulse(ref logic p, input int w);
        p = 1'b1;
        tick(w);
        p = 1'b0;
        tick(w + 8);
    endtask : pulse
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // Read data lands on the read edge and is checked 2 ns later
    always @(posedge clk) begin
        if (rd) begin
            #2;
            exp_b = expq.pop_front();
            `CHK(rdata, exp_b)
        end
    end
    always @(posedge clk) begin
        n[0] += cap;
        n[1] += capi;
        n[2] += cnti;
        n[3] += p2i;
        n[4] += stc;
        cyc++;
        if (cyc == 6000) begin
            mismatches++;
            report_and_stop();
        end
    end

    initial begin
        tick(20);
        rst = 1'b0;
        acc(4'h0, 4'h1, 1'b0, 8'h80);
        put(4'h4, 8'hFF);
        for (int a = 0; a < 6; a++) get(4'(a), 8'h00);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            {d4, d5, d6} = seed[2:0];
            tick(2);
            `CHK(pin6, d6)
            `CHK(pin4, d4)
            `CHK(pin5, d5)
        end
        put(4'h3, 8'h01);
        for (int k = 0; k < 16; k++) begin
            put(4'h0, 8'h00);
            put(4'h2, 8'h00);
            put(4'h1, {4'b0100 | 4'(k >> 2), 2'b00, 2'(k)});
            put(4'h0, 8'h81);
            put(4'h2, 8'h81);
            tick(3);
            `CHK(pin6, gate(4'(k)))
            `CHK(pin4, k[1])
            `CHK(pin5, k[0])
        end
        put(4'h0, 8'h00);
        put(4'h2, 8'h00);
        put(4'h1, 8'h00);
        put(4'h3, 8'h03);
        interrupt_mask = 8'h80;
        put(4'h0, 8'h81);
        n = '{default: 0};
        go = 1'b1;
        tick(40);
        go = 1'b0;
        tick(4);
        `CHK(n[2], n[4])
        `CHK(pin4, n[4][0])
        interrupt_mask = 8'h00;
        n = '{default: 0};
        go = 1'b1;
        tick(20);
        go = 1'b0;
        tick(4);
        `CHK(n[2], 0)
        put(4'h0, 8'h00);
        put(4'h2, 8'h01);
        put(4'h1, 8'h0C);
        tick(2);
        `CHK(pin5, 1'b1)
        put(4'h1, 8'h08);
        tick(2);
        `CHK(pin5, 1'b0)
        put(4'h2, 8'h00);
        put(4'h1, 8'h04);
        put(4'h0, 8'h80);
        go = 1'b1;
        for (int i = 0; i < 60 && !lrun; i++) tick(1);
        `CHK(srun, 1'b0)
        `CHK(lrun, 1'b1)
        for (int i = 0; i < 60 && !srun; i++) tick(1);
        `CHK(lrun, 1'b0)
        go = 1'b0;
        tick(2);
        get(4'h0, 8'hA0);
        get(4'h2, 8'h20);
        put(4'h0, 8'h20);
        get(4'h0, 8'h00);
        interrupt_mask = 8'h84;
        put(4'h3, 8'h04);
        put(4'h1, 8'h80);
        for (int e = 0; e < 4; e++) begin
            put(4'h1, {2'b10, 2'(e), 4'b0011});
            n = '{default: 0};
            pulse(p31, 8);
            ec = (e == 2) ? 2 : int'(e < 2);
            `CHK(n[0], ec)
            `CHK(n[1], ec)
            `CHK(n[3], ec)
            get(4'h1, {2'b10, 2'(e), 4'b0011});
        end
        put(4'h1, 8'hA0);
        pulse(p31, 8);
        get(4'h1, 8'hA3);
        put(4'h1, 8'hA2);
        get(4'h1, 8'hA1);
        put(4'h1, 8'hA1);
        get(4'h1, 8'hA0);
        put(4'h1, 8'hE0);
        n = '{default: 0};
        pulse(p31, 8);
        `CHK(n[0], 0)
        pulse(p20, 8);
        `CHK(n[0], 2)
        `CHK(n[3], 0)
        interrupt_mask = 8'h04;
        put(4'h1, 8'hA0);
        n = '{default: 0};
        pulse(p31, 8);
        `CHK(n[0], 2)
        `CHK(n[1] + n[3], 0)
        for (int f = 1; f < 3; f++) begin
            put(4'h1, {4'b1001, 2'(f), 2'b00});
            n = '{default: 0};
            pulse(p31, 4 * f - 2);
            pulse(p31, 4 * f + 4);
            `CHK(n[0], 1)
        end
        put(4'h1, 8'h00);
        n = '{default: 0};
        pulse(p31, 8);
        `CHK(n[0], 0)
        put(4'h1, 8'h3C);
        stop = 1'b1;
        tick(1);
        stop = 1'b0;
        get(4'h1, 8'h30);
        tick(4);
        report_and_stop();
    end
endmodule : dtc_common_ctrl_test

// File: dtc_input_filter.sv
`include "dtc_map.svh"

module dtc_input_filter #(
    parameter int CNT_W = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_pin,
    input wire logic [CNT_W-1:0] i_len,
    output logic o_rise,
    output logic o_fall
);
    import dtc_pkg::*;

    logic sync1_q;
    logic sync2_q;
    logic stable_q;
    logic stable_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic rise_q;
    logic fall_q;
    wire logic differs = sync2_q != stable_q;
    wire logic [CNT_W-1:0] cnt_inc = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    wire logic settled = (i_len == '0) || (cnt_inc >= i_len);

    // Level must hold i_len cycles before it is accepted
    always_comb begin
        stable_d = stable_q;
        cnt_d = '0;
        if (differs && settled) begin
            stable_d = sync2_q;
        end else if (differs) begin
            cnt_d = cnt_inc;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            stable_q <= 1'b0;
            cnt_q <= '0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            sync1_q <= i_pin;
            sync2_q <= sync1_q;
            stable_q <= stable_d;
            cnt_q <= cnt_d;
            rise_q <= stable_d & ~stable_q;
            fall_q <= ~stable_d & stable_q;
        end
    end

    assign o_rise = rise_q;
    assign o_fall = fall_q;
endmodule : dtc_input_filter

// File: dtc_map.svh
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH

// Bank and offsets inside expanded register bank
`define DTC_BANK 4'hD
`define DTC_OFS_SHORT_CTL 4'h0
`define DTC_OFS_COMMON 4'h1
`define DTC_OFS_LONG_CTL 4'h2
`define DTC_OFS_EXTRA 4'h3

// Common control field positions
`define DTC_B_MODE 7
`define DTC_B_SEL 6
`define DTC_B_LOGIC_HI 5
`define DTC_B_LOGIC_LO 4
`define DTC_B_SUB_HI 3
`define DTC_B_SUB_LO 2
`define DTC_B_INIT_SHORT 1
`define DTC_B_INIT_LONG 0

// Timer control field positions
`define DTC_B_ENABLE 7
`define DTC_B_TIMEOUT 5
`define DTC_B_OUT_EN 0

// Extra control field positions
`define DTC_B_CAP_MASK 2
`define DTC_B_CNT_MASK 1
`define DTC_B_PIN4_SEL 0

// Interrupt mask bits
`define DTC_IMR_GLOBAL 7
`define DTC_IMR_PORT2 2

`define DTC_RST_BYTE 8'h00

// Glitch filter lengths in clock cycles
`define DTC_FILT_NONE 4'h0
`define DTC_FILT_4 4'h4
`define DTC_FILT_8 4'h8

`endif

// File: dtc_pkg.sv
package dtc_pkg;
    typedef enum logic [1:0] {
        DTC_GATE_AND = 2'b00,
        DTC_GATE_OR = 2'b01,
        DTC_GATE_NOR = 2'b10,
        DTC_GATE_NAND = 2'b11
    } dtc_gate_t;

    typedef enum logic [1:0] {
        DTC_EDGE_FALL = 2'b00,
        DTC_EDGE_RISE = 2'b01,
        DTC_EDGE_BOTH = 2'b10,
        DTC_EDGE_RSVD = 2'b11
    } dtc_edge_t;

    typedef enum logic [1:0] {
        DTC_SUB_NORMAL = 2'b00,
        DTC_SUB_PINGPONG = 2'b01,
        DTC_SUB_LONG_LOW = 2'b10,
        DTC_SUB_LONG_HIGH = 2'b11
    } dtc_sub_t;

    typedef logic [7:0] dtc_byte_t;
endpackage : dtc_pkg

// File: dtc_timer_model.sv
module dtc_timer_model #(
    parameter int PER = 6
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic i_short_run,
    input wire logic i_long_run,
    output logic o_short_tc,
    output logic o_long_tc
);
    logic [3:0] s_q;
    logic [3:0] l_q;
    wire s_end = i_go && i_short_run && s_q == 4'(PER - 1);
    wire l_end = i_go && i_long_run && l_q == 4'(PER - 1);

    // Each running timer ends its count every PER cycles with a one-cycle pulse
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            s_q <= 4'h0;
            l_q <= 4'h0;
            o_short_tc <= 1'b0;
            o_long_tc <= 1'b0;
        end else begin
            s_q <= (i_go && i_short_run && !s_end) ? s_q + 4'h1 : 4'h0;
            l_q <= (i_go && i_long_run && !l_end) ? l_q + 4'h1 : 4'h0;
            o_short_tc <= s_end;
            o_long_tc <= l_end;
        end
    end
endmodule : dtc_timer_model
